// >>> rtl/cyl_latch.v
`timescale 1ns/100ps
`include "drive_select_and_cylinder_tag_defines.vh"
// ==========================================================
// Cylinder address register with both extension schemes
module cyl_latch (
	input  wire                      clk_i,      // System clock
	input  wire                      rstn_i,     // Sync reset, active low
	input  wire                      ce_i,       // Clock enable
	input  wire                      load_lo_i,  // Cylinder tag load
	input  wire                      load_hi_i,  // Head tag load
	input  wire                      ext1_i,     // Extension via cylinder tag
	input  wire                      ext2_i,     // Extension via head tag
	input  wire [`CYL_LOW_WIDTH-1:0] lines_i,    // Bus-out lines
	input  wire                      ext_line_i, // Tag-four lines
	output wire [`CYL_WIDTH-1:0]     next_o,     // Value the cylinder tag loads
	output reg  [`CYL_WIDTH-1:0]     cyl_o       // Latched address
);
	reg hi_bit;

	// Bit ten comes from the tag-four lines, the head tag, or is zero
	always @* begin
		if (ext1_i) begin
			hi_bit = ext_line_i;
		end else if (ext2_i) begin
			hi_bit = cyl_o[`CYL_LOW_WIDTH];
		end else begin
			hi_bit = 1'b0;
		end
	end

	// Line n carries weight two to the n
	assign next_o = {hi_bit, lines_i};

	// Value holds until the next load
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			cyl_o <= `CYL_RESET;
		end else if (ce_i) begin
			if (load_lo_i) begin
				cyl_o <= next_o;
			end else if (load_hi_i & ext2_i) begin
				cyl_o[`CYL_LOW_WIDTH] <= lines_i[`HI_BIT_LINE];
			end
		end
	end
endmodule

// >>> rtl/drive_select_and_cylinder_tag.v
//Contract
// - On select tag, drive compares select lines with its own address.
// - Own address comes from switches, any value 0 to 15.
// - Match raised only on equal address and cable-absent inactive.
// - Cable-absent inactive only with cable, controller power, channel enabled.
// - Cylinder tag starts a seek toward the latched address.
// - Without extension, cylinder tag loads ten bus-out lines.
// - With cylinder-tag extension, bit ten comes from tag-four lines.
// - Cylinder above 1216 is refused and reports a seek error.
// - During the cylinder tag, status is returned on bus-in lines.
// - Ready only when at speed, first seek good, no fault.
// - All tags ignored until the drive is selected.
`timescale 1ns/100ps
`include "drive_select_and_cylinder_tag_defines.vh"
module drive_select_and_cylinder_tag #(
	parameter ADDR_W = 4,
	parameter BIN_W  = 8
) (
	input  wire                  SYS_CLK_I,       // 40 MHz system clock
	input  wire                  RSTN_I,          // Sync reset, active low
	input  wire                  CE_I,            // Clock enable
	input  wire                  SEL_TAG_I,       // Unit select tag
	input  wire [ADDR_W-1:0]     SEL_ADDR_I,      // Unit select lines
	input  wire [ADDR_W-1:0]     OWN_ADDR_I,      // Address switches
	input  wire                  CABLE_OK_I,      // Primary cable attached
	input  wire                  POWER_OK_I,      // Controller powered
	input  wire                  CHAN_OFF_I,      // Channel disabled
	input  wire                  CYL_TAG_I,       // Cylinder select tag
	input  wire                  HEAD_TAG_I,      // Head tag (tag two)
	input  wire [9:0]            OUT_LINE_I,      // Bus-out lines 0..9
	input  wire                  EXT_LINE_I,      // Tag-four lines
	input  wire                  AT_SPEED_I,      // Spindle up to speed
	input  wire                  FAULT_I,         // Any fault present
	input  wire                  ON_CYL_I,        // Positioner on cylinder
	input  wire                  SEEK_DONE_I,     // Positioner finished a seek
	output wire                  SELECTED_O,      // Unit selected
	output reg                   SEEK_START_O,    // Seek start pulse
	output wire [`CYL_WIDTH-1:0] CYL_ADDR_O,      // Latched cylinder address
	output reg  [BIN_W-1:0]      IN_LINE_O,       // Bus-in lines
	output reg                   IN_LINE_OE_O,    // Bus-in drivers on
	input  wire [3:0]            REG_ADDR_I,      // Register address
	input  wire [31:0]           REG_WDATA_I,     // Register write data
	input  wire                  REG_WR_I,        // Write strobe
	input  wire                  REG_RD_I,        // Read strobe
	output reg  [31:0]           REG_RDATA_O,     // Read data, next cycle
	output wire                  IRQ_O            // Level interrupt
);
	// ==========================================================
	// Declarations
	wire                  match;
	wire [`CYL_WIDTH-1:0] next_cyl;
	wire                  cyl_rise;
	wire                  head_rise;
	wire                  legal;
	wire                  seek_go;
	wire                  seek_bad;
	wire                  unit_ready;
	wire                  clr_err;
	wire [`IRQ_WIDTH-1:0] irq_events;
	reg  [1:0]            ctrl;
	reg  [`IRQ_WIDTH-1:0] irq_status;
	reg  [`IRQ_WIDTH-1:0] irq_mask;
	reg  [`IRQ_WIDTH-1:0] next_irq_status;
	reg                   cyl_tag_d;
	reg                   head_tag_d;
	reg                   seek_err;
	reg                   first_seek_ok;
	reg                   seek_pending;
	reg                   selected_d;

	// ==========================================================
	// Helper functions
	// True when a cylinder number lies inside the recording field
	function in_range;
		input [`CYL_WIDTH-1:0] cyl;
		begin
			in_range = (cyl <= `CYL_MAX);
		end
	endfunction

	// Zero-extends the cylinder address to the bus width
	function [31:0] pad32;
		input [`CYL_WIDTH-1:0] v;
		begin
			pad32 = {21'h000000, v};
		end
	endfunction

	// One place decides whether a strobe addresses a given register
	function reg_hit;
		input       strobe;
		input [3:0] addr;
		input [3:0] target;
		begin
			reg_hit = strobe & (addr == target);
		end
	endfunction

	// ==========================================================
	// Selection compare
	// Registered so the select lines have a full cycle to settle before use
	unit_match #(
		.ADDR_W     (ADDR_W)
	) u_match (
		.clk_i      (SYS_CLK_I),
		.rstn_i     (RSTN_I),
		.ce_i       (CE_I),
		.sel_tag_i  (SEL_TAG_I),
		.sel_addr_i (SEL_ADDR_I),
		.own_addr_i (OWN_ADDR_I),
		.cable_ok_i (CABLE_OK_I),
		.power_ok_i (POWER_OK_I),
		.chan_off_i (CHAN_OFF_I),
		.match_o    (match)
	);

	// The select tag is raised by the controller with its address
	assign SELECTED_O = match;

	// ==========================================================
	// Tag edge detection
	// Tags count only while selected, so an unselected drive sees nothing
	// Delayed copies reset low, as idle tags are, so reset makes no false edge
	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			cyl_tag_d  <= 1'b0;
			head_tag_d <= 1'b0;
			selected_d <= 1'b0;
		end else if (CE_I) begin
			cyl_tag_d  <= CYL_TAG_I & match;
			head_tag_d <= HEAD_TAG_I & match;
			selected_d <= match;
		end
	end

	// Receivers gated by selection
	assign cyl_rise  = CYL_TAG_I & match & ~cyl_tag_d;
	assign head_rise = HEAD_TAG_I & match & ~head_tag_d;

	// ==========================================================
	// Cylinder address register
	// Head tag must come first when extension is on that tag
	// Bit ten source is chosen inside the latch; extension one outranks two
	cyl_latch u_cyl (
		.clk_i      (SYS_CLK_I),
		.rstn_i     (RSTN_I),
		.ce_i       (CE_I),
		.load_lo_i  (cyl_rise),
		.load_hi_i  (head_rise),
		.ext1_i     (ctrl[`CTRL_EXT1_BIT]),
		.ext2_i     (ctrl[`CTRL_EXT2_BIT]),
		.lines_i    (OUT_LINE_I),
		.ext_line_i (EXT_LINE_I),
		.next_o     (next_cyl),
		.cyl_o      (CYL_ADDR_O)
	);

	// ==========================================================
	// Seek launch and legality
	// Only the cylinder tag edge launches or refuses a seek
	// A refused address is still latched so software can read what was asked
	assign legal    = in_range(next_cyl);
	assign seek_go  = cyl_rise & legal;
	assign seek_bad = cyl_rise & ~legal;

	// Seek start pulse one cycle after the tag edge
	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			SEEK_START_O <= 1'b0;
		end else if (CE_I) begin
			SEEK_START_O <= seek_go;
		end
	end

	// ==========================================================
	// Seek error and first-seek tracking
	// Clear request comes from software; a new error in the same cycle wins
	assign clr_err = reg_hit(REG_WR_I, REG_ADDR_I, `REG_CTRL) & REG_WDATA_I[`CTRL_CLR_ERR_BIT];

	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			seek_err      <= 1'b0;
			first_seek_ok <= 1'b0;
			seek_pending  <= 1'b0;
		end else if (CE_I) begin
			if (seek_bad) begin
				seek_err <= 1'b1;
			end else if (clr_err) begin
				seek_err <= 1'b0;
			end
			if (seek_go) begin
				seek_pending <= 1'b1;
			end else if (SEEK_DONE_I) begin
				seek_pending <= 1'b0;
			end
			// First completed seek without error arms readiness
			if (SEEK_DONE_I & seek_pending & ~seek_err) begin
				first_seek_ok <= 1'b1;
			end
		end
	end

	// Fault drops readiness at once; the first-seek flag never falls after reset
	// Ready needs speed, a good first seek and no fault
	assign unit_ready = AT_SPEED_I & first_seek_ok & ~FAULT_I;

	// ==========================================================
	// Bus-in status
	// Status goes out while the cylinder tag is held on a selected drive
	// Drivers come on one cycle after the tag; upper lines carry nothing here
	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			IN_LINE_O    <= {BIN_W{1'b0}};
			IN_LINE_OE_O <= 1'b0;
		end else if (CE_I) begin
			IN_LINE_OE_O                 <= CYL_TAG_I & match;
			IN_LINE_O                    <= {BIN_W{1'b0}};
			IN_LINE_O[`BIN_READY_BIT]    <= unit_ready;
			IN_LINE_O[`BIN_ONCYL_BIT]    <= ON_CYL_I;
			IN_LINE_O[`BIN_SEEKERR_BIT]  <= seek_err | seek_bad;
			IN_LINE_O[`BIN_FAULT_BIT]    <= FAULT_I;
		end
	end

	// ==========================================================
	// Control register
	// Bit two is a write-one strobe for the seek error and is not stored
	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			ctrl <= `CTRL_RESET;
		end else if (CE_I) begin
			if (reg_hit(REG_WR_I, REG_ADDR_I, `REG_CTRL)) begin
				ctrl <= REG_WDATA_I[1:0];
			end
		end
	end

	// ==========================================================
	// Interrupt status, mask and output
	// Selection event is the rising edge of the registered match
	assign irq_events[`IRQ_SELECT_BIT] = match & ~selected_d;
	assign irq_events[`IRQ_SEEK_BIT]   = seek_go;
	assign irq_events[`IRQ_ERR_BIT]    = seek_bad;

	// A read clears the status, but an event in that cycle still sticks
	always @* begin
		next_irq_status = irq_status;
		if (reg_hit(REG_RD_I, REG_ADDR_I, `REG_IRQ_STATUS)) begin
			next_irq_status = {`IRQ_WIDTH{1'b0}};
		end
		next_irq_status = next_irq_status | irq_events;
	end

	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			irq_status <= `IRQ_RESET;
			irq_mask   <= `IRQ_RESET;
		end else if (CE_I) begin
			irq_status <= next_irq_status;
			if (reg_hit(REG_WR_I, REG_ADDR_I, `REG_IRQ_MASK)) begin
				irq_mask <= REG_WDATA_I[`IRQ_WIDTH-1:0];
			end
		end
	end

	// Level output; it falls only when software reads the status or masks it
	assign IRQ_O = |(irq_status & irq_mask);

	// ==========================================================
	// Register read port
	// Data stands only in the cycle after the strobe; unmapped reads give zero
	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			REG_RDATA_O <= 32'h00000000;
		end else if (CE_I) begin
			REG_RDATA_O <= 32'h00000000;
			if (REG_RD_I) begin
				case (REG_ADDR_I)
					// Layout: b5 ready, b4 first seek good, b3 seek error, b2 match, b1..0 mode
					`REG_CTRL: begin
						REG_RDATA_O <= {26'h0000000, unit_ready, first_seek_ok, seek_err, match, ctrl};
					end
					// The clearing side effect of this read lives with the status flops
					`REG_IRQ_STATUS: begin
						REG_RDATA_O <= {29'h00000000, irq_status};
					end
					`REG_IRQ_MASK: begin
						REG_RDATA_O <= {29'h00000000, irq_mask};
					end
					`REG_CYL: begin
						REG_RDATA_O <= pad32(CYL_ADDR_O);
					end
					default: begin
						REG_RDATA_O <= 32'h00000000;
					end
				endcase
			end
		end
	end
endmodule

// >>> rtl/drive_select_and_cylinder_tag_defines.vh
`ifndef DRIVE_SELECT_AND_CYLINDER_TAG_DEFINES_VH
`define DRIVE_SELECT_AND_CYLINDER_TAG_DEFINES_VH

// ==========================================================
// Register offsets (byte addresses on the plain port)
`define REG_CTRL          4'h0
`define REG_IRQ_STATUS    4'h4
`define REG_IRQ_MASK      4'h8
`define REG_CYL           4'hC

// ==========================================================
// Control register fields
`define CTRL_EXT1_BIT     0
`define CTRL_EXT2_BIT     1
`define CTRL_CLR_ERR_BIT  2
`define CTRL_RESET        2'h0

// ==========================================================
// Interrupt status and mask fields
`define IRQ_SELECT_BIT    0
`define IRQ_SEEK_BIT      1
`define IRQ_ERR_BIT       2
`define IRQ_WIDTH         3
`define IRQ_RESET         3'h0

// ==========================================================
// Bus-in status fields
`define BIN_READY_BIT     0
`define BIN_ONCYL_BIT     1
`define BIN_SEEKERR_BIT   2
`define BIN_FAULT_BIT     3

// ==========================================================
// Cylinder address limits and geometry
`define CYL_WIDTH         11
`define CYL_LOW_WIDTH     10
`define CYL_MAX           11'h4C0
`define CYL_RESET         11'h000
`define HI_BIT_LINE       0

`endif

// >>> rtl/unit_match.v
`timescale 1ns/100ps
// ==========================================================
// Unit address compare, qualified by cable presence
module unit_match #(
	parameter ADDR_W = 4
) (
	input  wire              clk_i,        // System clock
	input  wire              rstn_i,       // Sync reset, active low
	input  wire              ce_i,         // Clock enable
	input  wire              sel_tag_i,    // Unit select tag
	input  wire [ADDR_W-1:0] sel_addr_i,   // Address on select lines
	input  wire [ADDR_W-1:0] own_addr_i,   // Switch-set own address
	input  wire              cable_ok_i,   // Primary cable attached
	input  wire              power_ok_i,   // Controller powered
	input  wire              chan_off_i,   // Channel disabled
	output reg               match_o       // Selection match
);
	wire cable_absent;

	// Absent unless cable, power and channel are all good
	assign cable_absent = ~(cable_ok_i & power_ok_i & ~chan_off_i);

	// Compare only while the tag is seen
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			match_o <= 1'b0;
		end else if (ce_i) begin
			match_o <= sel_tag_i & (sel_addr_i == own_addr_i) & ~cable_absent;
		end
	end
endmodule

// >>> tb/ctrl_model.sv
`timescale 1ns/100ps
// ==========================================================
// Controller and positioner facing the drive port
module ctrl_model (
	input  wire       clk_i,        // Clock
	input  wire       seek_start_i, // Seek start
	output reg        sel_tag_o,    // Select tag
	output reg  [3:0] sel_addr_o,   // Select lines
	output reg        cyl_tag_o,    // Cylinder tag
	output reg        head_tag_o,   // Head tag
	output reg  [9:0] out_line_o,   // Bus-out
	output reg        ext_line_o,   // Tag-four lines
	output reg        seek_done_o   // Seek finished
);
	reg [2:0] dly = 3'h0;
	initial {sel_tag_o, sel_addr_o, cyl_tag_o, head_tag_o, out_line_o, ext_line_o, seek_done_o} = 19'h0;
	// Positioner ends each started seek three cycles later
	always @(posedge clk_i) begin
		seek_done_o <= (dly == 3'h1);
		if (seek_start_i)
			dly <= 3'h3;
		else if (dly != 3'h0)
			dly <= dly - 3'h1;
	end
	// Released select lines show the inverse, never a stale match
	task present_unit(input on, input [3:0] a);
		begin
			sel_tag_o  <= on;
			sel_addr_o <= on ? a : ~sel_addr_o;
		end
	endtask
	// Head tag first when the high bit rides on it; returns once the drive sampled
	task cyl_on(input [10:0] c, input via_head);
		begin
			if (via_head) begin
				@(posedge clk_i);
				head_tag_o <= 1'b1;
				out_line_o <= {~c[9:1], c[10]};
				@(posedge clk_i);
				head_tag_o <= 1'b0;
			end
			@(posedge clk_i);
			cyl_tag_o  <= 1'b1;
			out_line_o <= c[9:0];
			ext_line_o <= via_head ? ~c[10] : c[10];
			@(posedge clk_i);
			#1;
		end
	endtask
	task tags_off;
		begin
			@(posedge clk_i);
			cyl_tag_o  <= 1'b0;
			out_line_o <= ~out_line_o;
			ext_line_o <= ~ext_line_o;
		end
	endtask
endmodule

// >>> tb/drive_sel_cyl_assertions.sv
`timescale 1ns/100ps
`include "drive_select_and_cylinder_tag_defines.vh"
// ==========================================================
// Port checks on selection and the cylinder tag
module dsct_checker #(
	parameter ADDR_W = 4,
	parameter BIN_W  = 8
) (
	input wire              SYS_CLK_I,    // Clock
	input wire              RSTN_I,       // Reset, active low
	input wire              CE_I,         // Clock enable
	input wire              SEL_TAG_I,    // Select tag
	input wire [ADDR_W-1:0] SEL_ADDR_I,   // Select lines
	input wire [ADDR_W-1:0] OWN_ADDR_I,   // Switch address
	input wire              CABLE_OK_I,   // Cable attached
	input wire              POWER_OK_I,   // Controller powered
	input wire              CHAN_OFF_I,   // Channel disabled
	input wire              CYL_TAG_I,    // Cylinder tag
	input wire [9:0]        OUT_LINE_I,   // Bus-out
	input wire              AT_SPEED_I,   // At speed
	input wire              FAULT_I,      // Fault
	input wire              SELECTED_O,   // Selected
	input wire              SEEK_START_O, // Seek pulse
	input wire [10:0]       CYL_ADDR_O,   // Cylinder address
	input wire [BIN_W-1:0]  IN_LINE_O,    // Bus-in
	input wire              IN_LINE_OE_O  // Bus-in enable
);
	default clocking
		@(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	// A held tag must not count as a new one, so remember the last taken cycle
	reg  prev_hit;
	wire take = CE_I && CYL_TAG_I && SELECTED_O && !prev_hit;
	wire good = SEL_TAG_I && SEL_ADDR_I == OWN_ADDR_I && CABLE_OK_I && POWER_OK_I && !CHAN_OFF_I;
	always @(posedge SYS_CLK_I) begin
		if (!RSTN_I)
			prev_hit <= 1'b0;
		else if (CE_I)
			prev_hit <= CYL_TAG_I && SELECTED_O;
	end
	a_select_match: assert property (CE_I && good |=> SELECTED_O)
		else $error("match not selected");
	a_select_refuse: assert property (CE_I && !good |=> !SELECTED_O)
		else $error("selected without match");
	a_seek_cause: assert property (SEEK_START_O |-> $past(SELECTED_O) && $past(CYL_TAG_I))
		else $error("seek while unselected");
	a_seek_pulse: assert property (SEEK_START_O |=> !SEEK_START_O)
		else $error("seek pulse too long");
	a_seek_legal: assert property (take |=> SEEK_START_O == (CYL_ADDR_O <= `CYL_MAX))
		else $error("seek start wrong for address");
	a_cyl_lines: assert property (take |=> CYL_ADDR_O[9:0] == $past(OUT_LINE_I))
		else $error("low cylinder bits wrong");
	a_cyl_hold: assert property (!take |=> $stable(CYL_ADDR_O[9:0]))
		else $error("cylinder changed without tag");
	a_status_drive: assert property (take |=> IN_LINE_OE_O)
		else $error("bus-in not driven");
	a_ready_cause: assert property (IN_LINE_OE_O && IN_LINE_O[0] |-> $past(AT_SPEED_I) && !$past(FAULT_I))
		else $error("ready without speed or with fault");
endmodule

bind drive_select_and_cylinder_tag dsct_checker #(.ADDR_W(ADDR_W), .BIN_W(BIN_W)) i_chk (
	.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I), .SEL_TAG_I(SEL_TAG_I),
	.SEL_ADDR_I(SEL_ADDR_I), .OWN_ADDR_I(OWN_ADDR_I), .CABLE_OK_I(CABLE_OK_I),
	.POWER_OK_I(POWER_OK_I), .CHAN_OFF_I(CHAN_OFF_I), .CYL_TAG_I(CYL_TAG_I),
	.OUT_LINE_I(OUT_LINE_I), .AT_SPEED_I(AT_SPEED_I), .FAULT_I(FAULT_I),
	.SELECTED_O(SELECTED_O), .SEEK_START_O(SEEK_START_O), .CYL_ADDR_O(CYL_ADDR_O),
	.IN_LINE_O(IN_LINE_O), .IN_LINE_OE_O(IN_LINE_OE_O));

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	reg         clk = 1'b0;
	reg         rstn = 1'b0;
	reg         ce = 1'b1;
	reg  [3:0]  own = 4'h0;
	reg         cab = 1'b0, pwr = 1'b0, off = 1'b0, spd = 1'b0, flt = 1'b0, oncyl = 1'b0;
	reg  [3:0]  ra = 4'h0;
	reg  [31:0] wd = 32'h0;
	reg         wr = 1'b0, rd = 1'b0;
	wire        stag, ctag, htag, extl, done, sel, seek, oe, irq;
	wire [3:0]  saddr;
	wire [9:0]  ol;
	wire [10:0] cyl;
	wire [7:0]  inl;
	wire [31:0] rdat;
	integer     bad_count = 0;
	integer     samples_checked = 0;
	integer     cycles = 0;
	reg  [31:0] rng = 32'h0000894E;
	always #12.5 clk = ~clk;
	ctrl_model i_ctrl (.clk_i(clk), .seek_start_i(seek), .sel_tag_o(stag), .sel_addr_o(saddr), .cyl_tag_o(ctag),
		.head_tag_o(htag), .out_line_o(ol), .ext_line_o(extl), .seek_done_o(done));
	drive_select_and_cylinder_tag i_dut (.SYS_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .SEL_TAG_I(stag),
		.SEL_ADDR_I(saddr), .OWN_ADDR_I(own), .CABLE_OK_I(cab), .POWER_OK_I(pwr), .CHAN_OFF_I(off),
		.CYL_TAG_I(ctag), .HEAD_TAG_I(htag), .OUT_LINE_I(ol), .EXT_LINE_I(extl), .AT_SPEED_I(spd),
		.FAULT_I(flt), .ON_CYL_I(oncyl), .SEEK_DONE_I(done), .SELECTED_O(sel), .SEEK_START_O(seek),
		.CYL_ADDR_O(cyl), .IN_LINE_O(inl), .IN_LINE_OE_O(oe), .REG_ADDR_I(ra), .REG_WDATA_I(wd),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .IRQ_O(irq));
	// ==========================================================
	// Helpers
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	// Mode 0 ignores the extra high bit; both extension modes keep it
	function [10:0] exp_cyl(input [10:0] c, input [1:0] m);
		exp_cyl = (m == 2'h0) ? {1'b0, c[9:0]} : c;
	endfunction
	task check(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task reg_wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge clk);
			wr <= 1'b1;
			ra <= a;
			wd <= d;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task reg_rd(input [3:0] a, output [31:0] d);
		begin
			@(posedge clk);
			rd <= 1'b1;
			ra <= a;
			@(posedge clk);
			rd <= 1'b0;
			#1;
			d = rdat;
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// A hang counts as a mismatch
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 2000) begin
			bad_count = bad_count + 1;
			complete_run;
		end
	end
	// ==========================================================
	// Main sequence
	initial begin : main
		integer    i;
		reg [10:0] c, e;
		reg [1:0]  m;
		reg [31:0] d;
		reg        ok, legal;
		ok = 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 32; i = i + 1) begin
			@(posedge clk);
			rng = xs(rng);
			own <= i[3:0];
			{cab, pwr, off} <= {rng[8] | rng[9], rng[10] | rng[11], rng[12] & rng[13]};
			i_ctrl.present_unit(rng[14] | rng[15], rng[0] ? i[3:0] : rng[7:4]);
			@(posedge clk);
			#1;
			check(sel, stag && saddr == own && cab && pwr && !off);
		end
		$display("test selection done");
		// The last random pass may have left the drive selected
		@(posedge clk);
		i_ctrl.present_unit(1'b0, 4'h0);
		i_ctrl.cyl_on(11'h155, 1'b0);
		check({seek, oe, cyl}, 32'h0);
		i_ctrl.tags_off;
		@(posedge clk);
		{cab, pwr, off} <= 3'h6;
		i_ctrl.present_unit(1'b1, own);
		// Let the selection event land before the clearing read
		repeat (2) @(posedge clk);
		reg_rd(4'h4, d);
		check(d, 32'h1);
		$display("test unselected done");
		// Corners first, then random addresses across all three modes
		for (i = 0; i < 18; i = i + 1) begin
			rng = xs(rng);
			m = 2'(i % 3);
			c = (i == 0) ? 11'h005 : (i == 1) ? 11'h4C0 : (i == 2) ? 11'h4C1 : (i == 3) ? 11'h7FF :
				(i == 4) ? 11'h7FF : (i == 5) ? 11'h400 : rng[10:0];
			{spd, flt, oncyl} <= {rng[20] | rng[21], rng[22] & rng[23], rng[24]};
			reg_wr(4'h8, {29'h0, rng[27:25]});
			reg_wr(4'h0, {29'h0, 1'b1, m});
			i_ctrl.cyl_on(c, m == 2'h2);
			e = exp_cyl(c, m);
			legal = (e <= 11'h4C0);
			check(cyl, e);
			check(seek, legal);
			check({oe, inl[2]}, {1'b1, !legal});
			check(inl[0], spd && ok && !flt);
			check(inl, {4'h0, flt, !legal, oncyl, spd && ok && !flt});
			i_ctrl.tags_off;
			#1;
			ok = ok | legal;
			check(irq, |({!legal, legal, 1'b0} & rng[27:25]));
			reg_rd(4'h4, d);
			check(d, {29'h0, !legal, legal, 1'b0});
			check(irq, 1'b0);
		end
		repeat (8) @(posedge clk);
		#1;
		check(cyl, e);
		reg_rd(4'hC, d);
		check(d, {21'h0, e});
		reg_rd(4'h2, d);
		check(d, 32'h0);
		// A tag edge while the clock enable is low must leave no trace
		@(posedge clk);
		ce <= 1'b0;
		i_ctrl.cyl_on(11'h0AA, 1'b0);
		check({seek, cyl}, {1'b0, e});
		i_ctrl.tags_off;
		@(posedge clk);
		ce <= 1'b1;
		$display("test seeks done");
		complete_run;
	end
endmodule
